// ---- rtl/pcc_clock_ctrl.sv ----
// pll programming, clock pin selection and receive-mode clocking control
//
// Behaviour
// - both plls share one field layout
// - user divider 2/4/8/12, doubled by post halver
// - input halver divides oscillator by two
// - master pin: input, first, second, oscillator
// - clock out: off, first, second, oscillator
// - receiver drives first pll multipliers while receiving
// - incoming rate picks one of three modes
// - receive mode ignores second divider; first pll takes second halver
// - receive mode post halver picks 256fs or 128fs
// - second pll resets to 12MHz receive values
// - hardware mode locks registers, loads defaults
// - hardware mode forces receive mode automatically
// - hardware mode keeps master clock at 256fs
// - hardware mode keeps master pin an input
`timescale 1ns/1ps
`include "pcc_regs.svh"

module pcc_clock_ctrl
    import pcc_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_reset,
    input  wire logic         i_hw_mode,
    input  wire pcc_reg_req_t i_reg_req,
    output logic [8:0]        o_reg_rdata,
    input  wire logic         i_first_pll_power_down,
    input  wire logic         i_second_pll_power_down,
    input  wire logic         i_receiver_power_down,
    input  wire logic         i_transceiver_power_down,
    input  wire logic [3:0]   i_rx_integer_mult,
    input  wire logic [21:0]  i_rx_fraction_mult,
    input  wire logic [16:0]  i_rx_rate_hz,
    input  wire logic         i_oscillator_clock,
    input  wire logic         i_first_pll_clock,
    input  wire logic         i_second_pll_clock,
    output logic              o_receive_mode,
    output pcc_rate_t         o_rx_rate_mode,
    output logic              o_first_pll_enable,
    output logic              o_second_pll_enable,
    output pcc_pll_cfg_t      o_first_pll_cfg,
    output pcc_pll_cfg_t      o_second_pll_cfg,
    output logic              o_master_clk_pin_out,
    output logic              o_master_clk_pin_oe_n,
    output logic              o_general_clock_output_pin,
    output logic              o_general_clock_output_pin_oe_n
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [4:0] user_divide(input logic [1:0] code, input logic post);
        logic [4:0] base;
        unique case (code)
            2'h0: base = `PCC_DIV_TWO;
            2'h1: base = `PCC_DIV_FOUR;
            2'h2: base = `PCC_DIV_EIGHT;
            2'h3: base = `PCC_DIV_TWELVE;
        endcase
        return post ? {base[3:0], 1'b0} : base;
    endfunction : user_divide

    // same layout for both banks, picked by bank base offset
    function automatic pcc_pll_cfg_t user_cfg(input logic [7:0][8:0] rf, input int bank);
        pcc_pll_cfg_t c;
        logic [8:0]   lo;
        logic [8:0]   mid;
        logic [8:0]   hi;
        logic [8:0]   ct;
        lo  = rf[bank];
        mid = rf[bank + 1];
        hi  = rf[bank + 2];
        ct  = rf[bank + 3];
        c.input_halver = ct[`PCC_INPUT_HALVER];
        c.int_mult     = hi[`PCC_INT_MULT];
        c.frac_mult    = {hi[`PCC_FRAC_HI], mid, lo};
        c.divide       = user_divide(ct[`PCC_DIV_CODE], ct[`PCC_POST_HALVER]);
        return c;
    endfunction : user_cfg

    function automatic pcc_rate_t classify(input logic [16:0] hz);
        if (hz >= `PCC_HIGH_MIN && hz <= `PCC_HIGH_MAX) begin
            return PCC_RATE_HIGH;
        end else if (hz >= `PCC_MID_MIN && hz <= `PCC_MID_MAX) begin
            return PCC_RATE_MID;
        end else if (hz >= `PCC_LOW_MIN && hz <= `PCC_LOW_MAX) begin
            return PCC_RATE_LOW;
        end
        return PCC_RATE_NONE;
    endfunction : classify

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    pcc_state_t   st_r;
    pcc_state_t   st_nxt;
    logic         rx_mode;
    logic [1:0]   mclk_src;
    logic [1:0]   general_clock_output_pin_src;
    logic         post_a;
    logic [4:0]   base_256;
    pcc_pll_cfg_t cfg_a;
    pcc_pll_cfg_t cfg_b;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rate  = rx_mode ? classify(i_rx_rate_hz) : PCC_RATE_NONE;
        st_nxt.rdata = '0;
        // registers answer nothing while the pins own the clocking
        if (!st_r.hw_mode && i_reg_req.addr < `PCC_AW'(`PCC_NREGS)) begin
            st_nxt.rdata = st_r.regs[i_reg_req.addr[2:0]];
            if (i_reg_req.wr) begin
                st_nxt.regs[i_reg_req.addr[2:0]] = i_reg_req.wdata;
            end
        end
        if (i_reset) begin
            st_nxt.regs[`PCC_A_FRAC_LO]   = `PCC_RST_FRAC_LO;
            st_nxt.regs[`PCC_A_FRAC_MID]  = `PCC_RST_FRAC_MID;
            st_nxt.regs[`PCC_A_INT_FRAC]  = `PCC_RST_INT_FRAC;
            st_nxt.regs[`PCC_A_CTRL]      = `PCC_RST_A_CTRL;
            st_nxt.regs[`PCC_B_FRAC_LO]   = `PCC_RST_FRAC_LO;
            st_nxt.regs[`PCC_B_FRAC_MID]  = `PCC_RST_FRAC_MID;
            st_nxt.regs[`PCC_B_INT_FRAC]  = `PCC_RST_INT_FRAC;
            st_nxt.regs[`PCC_B_CTRL_PINS] = `PCC_RST_B_CTRL;
            st_nxt.hw_mode                = i_hw_mode;
            st_nxt.rate                   = PCC_RATE_NONE;
            st_nxt.rdata                  = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        st_r <= st_nxt;
    end

    // ---------------------------------------------------------------
    // pll settings
    // ---------------------------------------------------------------
    // hardware mode runs the receiver regardless of power-down inputs
    assign rx_mode = st_r.hw_mode ||
                     (!i_receiver_power_down && !i_transceiver_power_down);
    assign post_a  = st_r.hw_mode ? 1'b0 : st_r.regs[`PCC_A_CTRL][`PCC_POST_HALVER];

    // f2 near 98.3MHz: /4 gives 256fs at 96k, /8 at 48k, /12 at 32k
    always_comb begin
        unique case (st_r.rate)
            PCC_RATE_HIGH: base_256 = `PCC_DIV_FOUR;
            PCC_RATE_MID:  base_256 = `PCC_DIV_EIGHT;
            PCC_RATE_LOW:  base_256 = `PCC_DIV_TWELVE;
            PCC_RATE_NONE: base_256 = `PCC_DIV_EIGHT;
        endcase
    end

    always_comb begin
        cfg_a = user_cfg(st_r.regs, `PCC_A_FRAC_LO);
        cfg_b = user_cfg(st_r.regs, `PCC_B_FRAC_LO);
        if (rx_mode) begin
            cfg_a.int_mult     = i_rx_integer_mult;
            cfg_a.frac_mult    = i_rx_fraction_mult;
            cfg_a.input_halver = cfg_b.input_halver;
            // 128fs is half the clock, so the post halver doubles the divide
            cfg_a.divide       = post_a ? {base_256[3:0], 1'b0} : base_256;
            cfg_b.divide       = `PCC_DIV_UNUSED;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign mclk_src   = st_r.hw_mode ? `PCC_SRC_NONE
                                     : st_r.regs[`PCC_B_CTRL_PINS][`PCC_MCLK_SRC];
    assign general_clock_output_pin_src = st_r.regs[`PCC_B_CTRL_PINS][`PCC_GENERAL_CLOCK_OUTPUT_PIN_SRC];

    // clocks pass through a plain mux; glitch-free switching relies on power-down
    always_comb begin
        unique case (mclk_src)
            `PCC_SRC_NONE:   o_master_clk_pin_out = 1'b0;
            `PCC_SRC_FIRST:  o_master_clk_pin_out = i_first_pll_clock;
            `PCC_SRC_SECOND: o_master_clk_pin_out = i_second_pll_clock;
            `PCC_SRC_OSC:    o_master_clk_pin_out = i_oscillator_clock;
        endcase
        unique case (general_clock_output_pin_src)
            `PCC_SRC_NONE:   o_general_clock_output_pin = 1'b0;
            `PCC_SRC_FIRST:  o_general_clock_output_pin = i_first_pll_clock;
            `PCC_SRC_SECOND: o_general_clock_output_pin = i_second_pll_clock;
            `PCC_SRC_OSC:    o_general_clock_output_pin = i_oscillator_clock;
        endcase
    end

    assign o_master_clk_pin_oe_n           = (mclk_src == `PCC_SRC_NONE);
    assign o_general_clock_output_pin_oe_n = (general_clock_output_pin_src == `PCC_SRC_NONE);
    assign o_reg_rdata                     = st_r.rdata;
    assign o_receive_mode                  = rx_mode;
    assign o_rx_rate_mode                  = st_r.rate;
    assign o_first_pll_enable  = st_r.hw_mode || !i_first_pll_power_down;
    assign o_second_pll_enable = st_r.hw_mode || !i_second_pll_power_down;
    assign o_first_pll_cfg     = cfg_a;
    assign o_second_pll_cfg    = cfg_b;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    user_divide_a: assert property (!rx_mode
        && st_r.regs[`PCC_B_CTRL_PINS][`PCC_DIV_CODE] == 2'h3
        && st_r.regs[`PCC_B_CTRL_PINS][`PCC_POST_HALVER]
        |-> o_second_pll_cfg.divide == 5'h18)
        else $error("second pll divider not 24 for code 11 post 1");
    halver_path_a: assert property (!rx_mode |->
        o_first_pll_cfg.input_halver == st_r.regs[`PCC_A_CTRL][`PCC_INPUT_HALVER])
        else $error("first input halver not from register");
    mclk_pin_a: assert property (st_r.regs[`PCC_B_CTRL_PINS][6:5] == 2'h3 && !st_r.hw_mode
        |-> !o_master_clk_pin_oe_n && o_master_clk_pin_out == i_oscillator_clock)
        else $error("master pin not driving oscillator");
    general_clock_output_pin_off_a: assert property (st_r.regs[`PCC_B_CTRL_PINS][8:7] == 2'h0
        |-> o_general_clock_output_pin_oe_n)
        else $error("clock out pin driven when off");
    rx_override_a: assert property (rx_mode |->
        o_first_pll_cfg.frac_mult == i_rx_fraction_mult && o_second_pll_cfg.divide == 5'h00)
        else $error("receive mode pll settings wrong");
    rate_mode_a: assert property (rx_mode && i_rx_rate_hz == 17'h0bb80
        |=> o_rx_rate_mode == PCC_RATE_MID)
        else $error("48k not classified as middle mode");
    fs256_a: assert property (rx_mode && !post_a && o_rx_rate_mode == PCC_RATE_LOW
        |-> o_first_pll_cfg.divide == 5'h0c)
        else $error("32k 256fs divide not 12");
    reset_b_a: assert property ($fell(i_reset) |->
        o_second_pll_cfg.frac_mult == 22'h36fd21 && o_second_pll_cfg.int_mult == 4'h7)
        else $error("second pll reset values wrong");
    locked_regs_a: assert property (st_r.hw_mode && i_reg_req.wr
        |=> $stable(st_r.regs) && o_reg_rdata == 9'h000)
        else $error("hardware mode register access not denied");
    hw_mclk_in_a: assert property (st_r.hw_mode |-> o_master_clk_pin_oe_n && rx_mode)
        else $error("hardware mode drives master pin");

    rx_high_c: cover property (rx_mode ##1 o_rx_rate_mode == PCC_RATE_HIGH);
    pin_second_c: cover property (!o_general_clock_output_pin_oe_n && general_clock_output_pin_src == 2'h2);
    write_read_c: cover property (i_reg_req.wr && i_reg_req.addr == 7'h07 ##1 !i_reg_req.wr);
    hw_mode_c: cover property (st_r.hw_mode && o_rx_rate_mode == PCC_RATE_LOW);

endmodule : pcc_clock_ctrl

// ---- inc/pcc_regs.svh ----
// register offsets, field positions, reset values and rate limits of the clock control block
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

`define PCC_NREGS         8
`define PCC_AW            7
`define PCC_DW            9
`define PCC_A_FRAC_LO     7'h00
`define PCC_A_FRAC_MID    7'h01
`define PCC_A_INT_FRAC    7'h02
`define PCC_A_CTRL        7'h03
`define PCC_B_FRAC_LO     7'h04
`define PCC_B_FRAC_MID    7'h05
`define PCC_B_INT_FRAC    7'h06
`define PCC_B_CTRL_PINS   7'h07
`define PCC_BANK_STRIDE   4

`define PCC_INPUT_HALVER  0
`define PCC_POST_HALVER   1
`define PCC_DIV_CODE      4:3
`define PCC_MCLK_SRC      6:5
`define PCC_GENERAL_CLOCK_OUTPUT_PIN_SRC    8:7
`define PCC_INT_MULT      7:4
`define PCC_FRAC_HI       3:0

`define PCC_RST_FRAC_LO   9'h121
`define PCC_RST_FRAC_MID  9'h17e
`define PCC_RST_INT_FRAC  9'h07d
`define PCC_RST_A_CTRL    9'h010
`define PCC_RST_B_CTRL    9'h190

`define PCC_SRC_NONE      2'h0
`define PCC_SRC_FIRST     2'h1
`define PCC_SRC_SECOND    2'h2
`define PCC_SRC_OSC       2'h3

`define PCC_DIV_UNUSED    5'h00
`define PCC_DIV_TWO       5'h02
`define PCC_DIV_FOUR      5'h04
`define PCC_DIV_EIGHT     5'h08
`define PCC_DIV_TWELVE    5'h0c

`define PCC_HIGH_MIN      17'h15516
`define PCC_HIGH_MAX      17'h17ac0
`define PCC_MID_MIN       17'h0aa8b
`define PCC_MID_MAX       17'h0bd60
`define PCC_LOW_MIN       17'h07bc0
`define PCC_LOW_MAX       17'h07e40

`endif

// ---- inc/pcc_pkg.sv ----
// types shared by the clock control block
package pcc_pkg;
    typedef enum logic [1:0] {
        PCC_RATE_NONE = 2'h0,
        PCC_RATE_HIGH = 2'h1,
        PCC_RATE_MID  = 2'h3,
        PCC_RATE_LOW  = 2'h2
    } pcc_rate_t;

    typedef struct packed {
        logic        input_halver;
        logic [3:0]  int_mult;
        logic [21:0] frac_mult;
        logic [4:0]  divide;
    } pcc_pll_cfg_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [8:0] wdata;
    } pcc_reg_req_t;

    typedef struct packed {
        logic [7:0][8:0] regs;
        logic            hw_mode;
        pcc_rate_t       rate;
        logic [8:0]      rdata;
    } pcc_state_t;
endpackage : pcc_pkg

// ---- dv/pcc_clock_ctrl_tb.sv ----
// self-checking bench for the pll clock control block
`timescale 1ns/1ps
`include "pcc_regs.svh"

module pcc_clock_ctrl_tb
    import pcc_pkg::*;
;
    logic         i_mclk = 1'b0;
    logic         i_reset = 1'b1;
    logic         i_hw_mode = 1'b0;
    pcc_reg_req_t req = '0;
    logic         pd_a = 1'b0, pd_b = 1'b0, rx_pd = 1'b1, tx_pd = 1'b1;
    logic [3:0]   rx_n = 4'h0;
    logic [21:0]  rx_k = 22'h0;
    logic [16:0]  rate = 17'h0;
    logic         osc = 1'b0, clk_a = 1'b0, clk_b = 1'b0;
    logic [8:0]   rdata;
    logic         rx_on, en_a, en_b, mo, moe, co, coe;
    pcc_rate_t    rmode;
    pcc_pll_cfg_t cfg_a, cfg_b;
    int           bad_count = 0;
    int           n_tests = 0;

    pcc_clock_ctrl dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_hw_mode(i_hw_mode),
        .i_reg_req(req), .o_reg_rdata(rdata), .i_first_pll_power_down(pd_a),
        .i_second_pll_power_down(pd_b), .i_receiver_power_down(rx_pd),
        .i_transceiver_power_down(tx_pd), .i_rx_integer_mult(rx_n),
        .i_rx_fraction_mult(rx_k), .i_rx_rate_hz(rate), .i_oscillator_clock(osc),
        .i_first_pll_clock(clk_a), .i_second_pll_clock(clk_b), .o_receive_mode(rx_on),
        .o_rx_rate_mode(rmode), .o_first_pll_enable(en_a), .o_second_pll_enable(en_b),
        .o_first_pll_cfg(cfg_a), .o_second_pll_cfg(cfg_b), .o_master_clk_pin_out(mo),
        .o_master_clk_pin_oe_n(moe), .o_general_clock_output_pin(co),
        .o_general_clock_output_pin_oe_n(coe));

    initial begin
        forever #2 i_mclk = ~i_mclk;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        req = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge i_mclk);
        #1;
        req.wr = 1'b0;
        // one idle edge so a following call never rewrites wr in this time step
        @(posedge i_mclk);
        #1;
    endtask : wr

    // rdata is registered: present address, let one edge pass, then compare
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        req.addr = a;
        @(posedge i_mclk);
        #1;
        chk(32'(rdata), 32'(exp));
    endtask : rd

    task automatic set_mult(input int bank, input logic [3:0] n, input logic [21:0] k);
        wr(7'(bank * 4), k[8:0]);
        wr(7'(bank * 4 + 1), k[17:9]);
        wr(7'(bank * 4 + 2), {1'b0, n, k[21:18]});
    endtask : set_mult

    task automatic do_reset(input logic hw);
        i_hw_mode = hw;
        i_reset = 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        i_reset = 1'b0;
    endtask : do_reset

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    logic [8:0]  rst_val [8] = '{9'h121, 9'h17e, 9'h07d, 9'h010, 9'h121, 9'h17e, 9'h07d, 9'h190};
    logic [4:0]  div_tab [4] = '{5'h02, 5'h04, 5'h08, 5'h0c};
    logic [16:0] rt  [8] = '{17'd96000, 17'd48480, 17'd43659, 17'd43658, 17'd32320, 17'd31680,
                             17'd87318, 17'd87317};
    pcc_rate_t   rm  [8] = '{PCC_RATE_HIGH, PCC_RATE_MID, PCC_RATE_MID, PCC_RATE_NONE,
                             PCC_RATE_LOW, PCC_RATE_LOW, PCC_RATE_HIGH, PCC_RATE_NONE};
    logic [4:0]  rd_div [8] = '{5'h04, 5'h08, 5'h08, 5'h08, 5'h0c, 5'h0c, 5'h04, 5'h08};
    logic [2:0]  lv;

    initial begin
        #(4 * 3000);
        bad_count++;
        close_out();
    end

    initial begin
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) rd(7'(i), rst_val[i]);
        chk({cfg_b.int_mult, 6'h0, cfg_b.frac_mult}, {4'h7, 6'h0, 22'h36fd21});
        wr(7'h08, 9'h0aa);
        rd(7'h08, 9'h000);
        rd(`PCC_A_FRAC_LO, 9'h121);
        // software-side arithmetic: n = whole part of ratio, k = 2^22 * remainder
        for (int b = 0; b < 2; b++) begin
            set_mult(b, 4'h8, 22'h0c49ba);
            chk(b ? cfg_b.frac_mult : cfg_a.frac_mult, 22'h0c49ba);
            chk(b ? cfg_b.int_mult : cfg_a.int_mult, 4'h8);
            set_mult(b, 4'hd, 22'h3fffff);
            chk(b ? cfg_b.frac_mult : cfg_a.frac_mult, 22'h3fffff);
        end
        for (int c = 0; c < 8; c++) begin
            wr(`PCC_A_CTRL, {4'h0, 2'(c >> 1), 1'b0, c[0], c[1]});
            wr(`PCC_B_CTRL_PINS, {4'h0, 2'(c >> 1), 1'b0, c[0], ~c[1]});
            chk(cfg_a.divide, div_tab[c >> 1] << c[0]);
            chk(cfg_b.divide, div_tab[c >> 1] << c[0]);
            chk({cfg_a.input_halver, cfg_b.input_halver}, {c[1], ~c[1]});
        end
        // pin sources; the pin direction is only changed with the plls down
        {pd_a, pd_b} = 2'b11;
        for (int s = 0; s < 4; s++) begin
            wr(`PCC_B_CTRL_PINS, {2'(3 - s), 2'(s), 5'h00});
            rd(`PCC_B_CTRL_PINS, {2'(3 - s), 2'(s), 5'h00});
            for (int v = 0; v < 2; v++) begin
                lv = v ? 3'b101 : 3'b010;
                {osc, clk_b, clk_a} = lv;
                @(posedge i_mclk);
                #1;
                chk(moe, s == 0);
                if (s != 0) chk(mo, lv[s - 1]);
                chk({coe, co}, s == 3 ? 2'b10 : {1'b0, lv[2 - s]});
            end
        end
        chk({en_a, en_b, rx_on}, 3'b000);
        pd_a = 1'b0;
        @(posedge i_mclk);
        #1;
        chk({en_a, en_b}, 2'b10);
        // receive start-up: second pll down, halvers and second pll, receiver, plls up
        wr(`PCC_A_CTRL, 9'h000);
        wr(`PCC_B_CTRL_PINS, 9'h01b);
        set_mult(1, 4'h7, 22'h36fd21);
        {rx_pd, tx_pd} = 2'b00;
        {pd_a, pd_b} = 2'b00;
        {rx_n, rx_k} = {4'h9, 22'h2aaaaa};
        @(posedge i_mclk);
        #1;
        chk({rx_on, en_a, en_b}, 3'b111);
        chk({cfg_a.int_mult, cfg_a.frac_mult}, {4'h9, 22'h2aaaaa});
        chk({cfg_a.input_halver, cfg_b.divide}, {1'b1, 5'h00});
        for (int i = 0; i < 8; i++) begin
            rate = rt[i];
            @(posedge i_mclk);
            #1;
            chk(rmode, rm[i]);
            chk(cfg_a.divide, rd_div[i]);
        end
        wr(`PCC_A_CTRL, 9'h002);
        chk(cfg_a.divide, 5'h10);
        tx_pd = 1'b1;
        @(posedge i_mclk);
        #1;
        chk({rx_on, rmode}, {1'b0, PCC_RATE_NONE});
        // hardware mode: registers shut, receive clocking forced
        {pd_a, pd_b} = 2'b11;
        do_reset(1'b1);
        wr(`PCC_B_CTRL_PINS, 9'h0ff);
        rd(`PCC_B_CTRL_PINS, 9'h000);
        chk({moe, coe, rx_on, en_a, en_b}, 5'b10111);
        chk(cfg_b.frac_mult, 22'h36fd21);
        rate = 17'd96000;
        @(posedge i_mclk);
        #1;
        chk({rmode, cfg_a.divide}, {PCC_RATE_HIGH, 5'h04});
        rate = 17'd48000;
        @(posedge i_mclk);
        #1;
        chk(cfg_a.divide, 5'h08);
        close_out();
    end
endmodule : pcc_clock_ctrl_tb
